// ### design/cgw_clock_ctrl.sv
// cgw_clock_ctrl: gear, reference select, pll control and watchdog service
// assumes classic Wishbone master, synchronous oscillator and pll tick inputs
//
// How it works
// [RL1] bit 12 stores doubler mode, 0 after reset; doubling itself is absent.
// [RL2] peripheral gear divides reference by 1, 2, 4, 8; reset gives 11.
// [RL3] software keeps peripheral clock at most 25 MHz and below cpu/2.
// [RL4] software steps both gears through a common ratio before targets.
// [RL5] doubler on freezes cpu gear at divide-by-one, field ignored.
// [RL6] software writes one into gear bit 9.
// [RL7] ref source bit: 1 halved oscillator (reset), 0 pll output.
// [RL8] while pll stop is 1, writing 0 to ref source is ignored.
// [RL9] stop mode halts pll but keeps stop bit; software waits afterward.
// [RL10] a5 then 5a into the key register clears the watchdog flip-flop; in a cycle with a timebase lap the code sets it instead.
// [RL11] key register reads return zero.
// [RL12] watchdog reset issues if key pair misses the selected period.
// [RL13] stop, sleep or bus hold clears the watchdog flip-flop; in a cycle with a timebase lap the code sets it instead.
// [RL14] cycle codes give 2^15..2^21 phi, reset within that and twice it.
// [RL15] phi is two oscillator periods or one pll period by source.
// [RL16] pll control writes only take effect while ref source is 1.
// [RL17] pll multiplier two bits, 00 after power-on only.
// [RL18] software writes zeros into pll control bits 13 and 12.
// [RL19] pll stop bit 0 runs, 1 stops; power-on reset only.
// [RL20] stop mode halts the pll regardless of the stop bit.
// [RL21] cpu and peripheral clocks have separate independent dividers.
// [RL22] a source change restarts both dividers together.
// [RL23] cpu gear at bits 15:14, coded like peripheral gear, reset 11.
// [RL24] watchdog cycle code at bits 9:8 of its register, reset 00.
// [RL25] read-only bit 13 shows the doubler mode in effect.
//
// Decided for this implementation: the address map and register access over Wishbone.
`timescale 1ns/10ps
module cgw_clock_ctrl #(
   parameter int WD_EXP_BASE = cgw_pkg::WD_EXP_BASE
) (
   input  wire logic                     clk_i,
   input  wire logic                     rst_i,
   input  wire logic                     por_i,
   input  wire logic                     wb_cyc_i,
   input  wire logic                     wb_stb_i,
   input  wire logic                     wb_we_i,
   input  wire logic [cgw_pkg::WB_AW-1:0] wb_adr_i,
   input  wire logic [3:0]               wb_sel_i,
   input  wire logic [31:0]              wb_dat_i,
   output logic [31:0]                   wb_dat_o,
   output logic                          wb_ack_o,
   input  wire logic                     osc_tick_i,
   input  wire logic                     pll_tick_i,
   input  wire logic                     stop_i,
   input  wire logic                     sleep_i,
   input  wire logic                     bus_hold_i,
   output logic                          cpu_tick_o,
   output logic                          periph_tick_o,
   output logic                          ref_src_o,
   output logic                          pll_run_o,
   output logic [1:0]                    pll_mult_o,
   output logic                          doubler_o,
   output logic                          wd_reset_o
);
   import cgw_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // registers
   logic [1:0] cpu_gear_q;
   logic [1:0] per_gear_q;
   logic       dbl_sel_q;
   logic       dbl_ack_q;
   logic       ref_src_q;
   logic       ref_src_d;
   logic [1:0] pll_mult_q;
   logic       pll_stop_q;
   logic [1:0] wd_cycle_q;
   logic       osc_half_q;
   logic       ack_q;
   logic [31:0] rdat_q;
   logic [31:0] rdat;
   cgw_key_e   key_q;
   cgw_key_e   key_d;

   ////////////////////////////////////////////////////////////////////////////////
   // bus decode
   wire        bus_req   = wb_cyc_i && wb_stb_i;
   wire        wr_now    = bus_req && wb_we_i && ack_q;
   wire        hit_gear  = (wb_adr_i == ADR_GEAR);
   wire        hit_pll   = (wb_adr_i == ADR_PLL);
   wire        hit_key   = (wb_adr_i == ADR_WDKEY);
   wire        hit_cyc   = (wb_adr_i == ADR_WDCYC);
   wire        wr_hi     = wr_now && wb_sel_i[1];
   wire        wr_lo     = wr_now && wb_sel_i[0];
   wire        wr_gear   = wr_hi && hit_gear;
   wire        wr_pll    = wr_hi && hit_pll && ref_src_q;                 // [RL16]
   wire        wr_key    = wr_lo && hit_key;
   wire        wr_cyc    = wr_hi && hit_cyc;
   wire [7:0]  key_byte  = wb_dat_i[7:0];
   wire        new_src   = wb_dat_i[GEAR_REF_SRC];

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;

   ////////////////////////////////////////////////////////////////////////////////
   // read mux
   always_comb begin
      rdat = 32'h0000_0000;
      if (hit_gear) begin
         rdat[GEAR_CPU_LO+:2] = cpu_gear_q;                              // [RL23]
         rdat[GEAR_DBL_ACK]   = dbl_ack_q;                               // [RL25]
         rdat[GEAR_DBL_SEL]   = dbl_sel_q;
         rdat[GEAR_PER_LO+:2] = per_gear_q;
         rdat[GEAR_RSV_ONE]   = 1'b1;
         rdat[GEAR_REF_SRC]   = ref_src_q;
      end else if (hit_pll) begin
         rdat[PLL_MULT_LO+:2] = pll_mult_q;
         rdat[PLL_STOP]       = pll_stop_q;
      end else if (hit_cyc) begin
         rdat[WDCYC_LO+:2]    = wd_cycle_q;
      end
      // key register and unmapped addresses read zero                   [RL11]
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || por_i) begin
         ack_q  <= 1'b0;
         rdat_q <= 32'h0000_0000;
      end else begin
         ack_q  <= bus_req && !ack_q;
         rdat_q <= (bus_req && !ack_q && !wb_we_i) ? rdat : 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // gear control register
   assign ref_src_d = (wr_gear && !(pll_stop_q && !new_src)) ? new_src     // [RL8]
                                                             : ref_src_q;

   always_ff @(posedge clk_i) begin
      if (rst_i || por_i) begin
         cpu_gear_q <= RST_CPU_GEAR;                                     // [RL23]
         per_gear_q <= RST_PER_GEAR;                                     // [RL2]
         dbl_sel_q  <= RST_DBL;                                          // [RL1]
         dbl_ack_q  <= RST_DBL;
         ref_src_q  <= RST_REF_SRC;                                      // [RL7]
      end else begin
         if (wr_gear) begin
            cpu_gear_q <= wb_dat_i[GEAR_CPU_LO+:2];
            per_gear_q <= wb_dat_i[GEAR_PER_LO+:2];
            dbl_sel_q  <= wb_dat_i[GEAR_DBL_SEL];                        // [RL1]
         end
         dbl_ack_q <= dbl_sel_q;                                         // [RL25]
         ref_src_q <= ref_src_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // pll control, power-on only
   always_ff @(posedge clk_i) begin
      if (por_i) begin
         pll_mult_q <= RST_PLL_MULT;                                     // [RL17]
         pll_stop_q <= RST_PLL_STOP;                                     // [RL19]
      end else if (wr_pll) begin
         pll_mult_q <= wb_dat_i[PLL_MULT_LO+:2];                         // [RL17]
         pll_stop_q <= wb_dat_i[PLL_STOP];                               // [RL19]
      end
   end

   assign pll_run_o  = !pll_stop_q && !stop_i;                           // [RL9] [RL20]
   assign pll_mult_o = pll_mult_q;
   assign ref_src_o  = ref_src_q;
   assign doubler_o  = dbl_ack_q;

   ////////////////////////////////////////////////////////////////////////////////
   // watchdog cycle register
   always_ff @(posedge clk_i) begin
      if (rst_i || por_i)
         wd_cycle_q <= RST_WD_CYCLE;                                     // [RL24]
      else if (wr_cyc)
         wd_cycle_q <= wb_dat_i[WDCYC_LO+:2];                            // [RL24]
   end

   ////////////////////////////////////////////////////////////////////////////////
   // reference tick: halved oscillator or pll
   wire osc_half_tick = osc_tick_i && osc_half_q;
   wire ref_tick      = ref_src_q ? osc_half_tick                        // [RL7]
                                  : (pll_tick_i && pll_run_o);
   wire src_change    = (ref_src_d != ref_src_q);

   always_ff @(posedge clk_i) begin
      if (rst_i || por_i)
         osc_half_q <= 1'b0;
      else if (osc_tick_i)
         osc_half_q <= !osc_half_q;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // independent cpu and peripheral dividers
   cgw_gear_if cpu_g ();
   cgw_gear_if per_g ();

   assign cpu_g.ref_tick = ref_tick;
   assign per_g.ref_tick = ref_tick;
   assign cpu_g.restart  = src_change;                                   // [RL22]
   assign per_g.restart  = src_change;                                   // [RL22]
   assign cpu_g.ratio    = dbl_ack_q ? 2'h0 : cpu_gear_q;                // [RL5]
   assign per_g.ratio    = per_gear_q;                                   // [RL2]
   assign cpu_tick_o     = cpu_g.tick;
   assign periph_tick_o  = per_g.tick;

   cgw_gear_div u_cpu_div (                                              // [RL21]
      .clk_i (clk_i),
      .rst_i (rst_i || por_i),
      .g     (cpu_g)
   );

   cgw_gear_div u_per_div (                                              // [RL21]
      .clk_i (clk_i),
      .rst_i (rst_i || por_i),
      .g     (per_g)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // watchdog key sequence
   wire key_fire = wr_key && (key_q == KEY_ARMED) && (key_byte == KEY_FIRE);
   wire wd_clear = key_fire || stop_i || sleep_i || bus_hold_i;          // [RL10] [RL13]

   always_comb begin
      key_d = key_q;
      if (wr_key) begin
         unique case (key_q)
            KEY_IDLE:  key_d = (key_byte == KEY_ARM) ? KEY_ARMED : KEY_IDLE;
            KEY_ARMED: key_d = (key_byte == KEY_ARM) ? KEY_ARMED : KEY_IDLE;
            default:   key_d = KEY_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || por_i)
         key_q <= KEY_IDLE;
      else
         key_q <= key_d;                                                 // [RL10]
   end

   ////////////////////////////////////////////////////////////////////////////////
   // watchdog timer on phi
   cgw_wdog #(
      .EXP_BASE (WD_EXP_BASE)
   ) u_wdog (
      .clk_i      (clk_i),
      .rst_i      (rst_i || por_i),
      .phi_tick_i (ref_tick),                                            // [RL15]
      .cycle_i    (wd_cycle_q),                                          // [RL14]
      .clear_i    (wd_clear),
      .wd_reset_o (wd_reset_o)                                           // [RL12]
   );

endmodule : cgw_clock_ctrl

// ### design/cgw_pkg.sv
// cgw_pkg: offsets, field positions, reset values and keys of the clock gear block
// assumes a 32-bit classic Wishbone register bus and one 100 MHz clock
package cgw_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // bus and timing
   localparam int          WB_AW          = 8;
   localparam int          CLK_PERIOD_NS  = 10;
   localparam int          WD_EXP_BASE    = 15;
   localparam int          GEAR_CW        = 3;

   ////////////////////////////////////////////////////////////////////////////////
   // byte offsets
   localparam logic [7:0]  ADR_GEAR       = 8'h00;
   localparam logic [7:0]  ADR_PLL        = 8'h04;
   localparam logic [7:0]  ADR_WDKEY      = 8'h08;
   localparam logic [7:0]  ADR_WDCYC      = 8'h0c;

   ////////////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int          GEAR_CPU_LO    = 14;
   localparam int          GEAR_DBL_ACK   = 13;
   localparam int          GEAR_DBL_SEL   = 12;
   localparam int          GEAR_PER_LO    = 10;
   localparam int          GEAR_RSV_ONE   = 9;
   localparam int          GEAR_REF_SRC   = 8;
   localparam int          PLL_MULT_LO    = 14;
   localparam int          PLL_STOP       = 11;
   localparam int          WDCYC_LO       = 8;

   ////////////////////////////////////////////////////////////////////////////////
   // values after reset and keys
   localparam logic [1:0]  RST_CPU_GEAR   = 2'h3;
   localparam logic [1:0]  RST_PER_GEAR   = 2'h3;
   localparam logic        RST_REF_SRC    = 1'b1;
   localparam logic        RST_DBL        = 1'b0;
   localparam logic [1:0]  RST_PLL_MULT   = 2'h0;
   localparam logic        RST_PLL_STOP   = 1'b0;
   localparam logic [1:0]  RST_WD_CYCLE   = 2'h0;
   localparam logic [7:0]  KEY_ARM        = 8'ha5;
   localparam logic [7:0]  KEY_FIRE       = 8'h5a;

   typedef enum logic [1:0] {
      KEY_IDLE  = 2'b01,
      KEY_ARMED = 2'b10
   } cgw_key_e;

endpackage : cgw_pkg

// ### design/cgw_gear_if.sv
// cgw_gear_if: reference tick, ratio and divided tick between controller and divider
// assumes one clock shared by both ends
`timescale 1ns/10ps
interface cgw_gear_if;
   logic       ref_tick;
   logic       restart;
   logic [1:0] ratio;
   logic       tick;
   modport ctrl (output ref_tick, output restart, output ratio, input tick);
   modport div  (input ref_tick, input restart, input ratio, output tick);
endinterface : cgw_gear_if

// ### design/cgw_gear_div.sv
// cgw_gear_div: divides the reference tick by 1, 2, 4 or 8
// assumes ref_tick is a one-cycle pulse and restart realigns the phase
`timescale 1ns/10ps
module cgw_gear_div (
   input  wire logic clk_i,
   input  wire logic rst_i,
   cgw_gear_if.div   g
);
   import cgw_pkg::*;

   logic [GEAR_CW-1:0] cnt_q;
   logic [GEAR_CW-1:0] cnt_d;
   logic [GEAR_CW-1:0] last;
   logic               wrap;
   logic               tick_q;

   assign last  = GEAR_CW'((1 << g.ratio) - 1);
   assign wrap  = g.ref_tick && (cnt_q >= last);
   assign cnt_d = g.restart ? '0 : (wrap ? '0 : (g.ref_tick ? cnt_q + 1'b1 : cnt_q));
   assign g.tick = tick_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q  <= '0;
         tick_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         tick_q <= wrap && !g.restart;
      end
   end

endmodule : cgw_gear_div

// ### design/cgw_wdog.sv
// cgw_wdog: timebase and watchdog flip-flop, reset after 2^n to 2^(n+1) phi
// assumes phi_tick_i pulses once per watchdog time unit
`timescale 1ns/10ps
module cgw_wdog #(
   parameter int EXP_BASE = cgw_pkg::WD_EXP_BASE
) (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       phi_tick_i,
   input  wire logic [1:0] cycle_i,
   input  wire logic       clear_i,
   output logic            wd_reset_o
);
   import cgw_pkg::*;

   localparam int TBW = EXP_BASE + 6;

   logic [TBW-1:0] tb_q;
   logic [TBW-1:0] mask;
   logic           lap;
   logic           ff_q;
   logic           rst_q;

   assign mask = TBW'((64'd1 << (EXP_BASE + 2 * int'(cycle_i))) - 64'd1);
   assign lap  = phi_tick_i && ((tb_q & mask) == mask);
   assign wd_reset_o = rst_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tb_q  <= '0;
         ff_q  <= 1'b0;
         rst_q <= 1'b0;
      end else begin
         tb_q  <= phi_tick_i ? tb_q + 1'b1 : tb_q;
         rst_q <= lap && ff_q && !clear_i;
         if (lap)
            ff_q <= !ff_q || clear_i;
         else if (clear_i)
            ff_q <= 1'b0;
      end
   end

endmodule : cgw_wdog

// ### bench/cgw_chk.sv
// cgw_chk: port-level assertions for the clock gear block
// assumes bind into cgw_clock_ctrl, one clock, resets rst_i and por_i
`timescale 1ns/10ps
module cgw_chk #(
   parameter int WD_EXP_BASE = 15
) (
   input  wire logic                      clk_i,
   input  wire logic                      rst_i,
   input  wire logic                      por_i,
   input  wire logic                      wb_cyc_i,
   input  wire logic                      wb_stb_i,
   input  wire logic                      wb_we_i,
   input  wire logic [cgw_pkg::WB_AW-1:0] wb_adr_i,
   input  wire logic [31:0]               wb_dat_o,
   input  wire logic                      wb_ack_o,
   input  wire logic                      stop_i,
   input  wire logic                      sleep_i,
   input  wire logic                      bus_hold_i,
   input  wire logic                      ref_src_o,
   input  wire logic                      pll_run_o,
   input  wire logic [1:0]                pll_mult_o,
   input  wire logic                      wd_reset_o
);
   import cgw_pkg::*;
   ////////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i || por_i);
   wire logic gear_wr_w = wb_ack_o && wb_we_i && (wb_adr_i == ADR_GEAR);
   wire logic pll_wr_w  = wb_ack_o && wb_we_i && (wb_adr_i == ADR_PLL) && ref_src_o;
   wire logic stby_w    = stop_i || sleep_i || bus_hold_i;
   sequence req_s;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence ans_s;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   ack_timing_a: assert property (req_s |=> ans_s)
      else $error("ack not one cycle after request");
   ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   rdata_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   ref_write_a: assert property ($changed(ref_src_o) |-> $past(gear_wr_w))
      else $error("ref source changed without gear write");
   pll_guard_a: assert property ($changed(pll_mult_o) |-> $past(pll_wr_w))
      else $error("pll multiplier changed outside allowed write");
   stop_halt_a: assert property (stop_i |-> !pll_run_o)
      else $error("pll runs in stop");
   wd_pulse_a: assert property (wd_reset_o |=> !wd_reset_o)
      else $error("watchdog reset longer than one cycle");
   stby_clear_a: assert property (stby_w [*3] |-> !wd_reset_o)
      else $error("watchdog reset during standby");
endmodule : cgw_chk

// ### bench/testbench.sv
// testbench: register, divider and watchdog checks of the clock gear block
// assumes cgw_pkg and the design files compiled first
`timescale 1ns/10ps
module testbench;
   import cgw_pkg::*;
   localparam int WDB = 3;
   logic        clk_i = 1'b0, rst_i = 1'b1, por_i = 1'b1;
   logic        wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, osc_tick = 1'b1, pll_tick = 1'b0;
   logic [7:0]  wb_adr = 8'h00;
   logic [3:0]  wb_sel = 4'h0;
   logic [31:0] wb_wdat = 32'h0, q;
   logic [2:0]  stby = 3'h0;
   logic [1:0]  pll_div = 2'h0;
   wire logic [31:0] rdat;
   wire logic [1:0]  mult;
   wire logic        ack, cpu_t, per_t, ref_src, pll_run, dbl, wd_rst;
   int mismatches = 0, tests_run = 0, hits = 0, p, n;
   ////////////////////////////////////////////////////////////////////////////////
   cgw_clock_ctrl #(.WD_EXP_BASE(WDB)) cgw_clock_ctrl_inst (
      .clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .osc_tick_i(osc_tick), .pll_tick_i(pll_tick),
      .stop_i(stby[0]), .sleep_i(stby[1]), .bus_hold_i(stby[2]), .cpu_tick_o(cpu_t),
      .periph_tick_o(per_t), .ref_src_o(ref_src), .pll_run_o(pll_run), .pll_mult_o(mult),
      .doubler_o(dbl), .wd_reset_o(wd_rst));
   always #5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      pll_div  <= (pll_div == 2'h2) ? 2'h0 : pll_div + 2'h1;
      pll_tick <= (pll_div == 2'h2);
      if (wd_rst === 1'b1) hits <= hits + 1;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_sim;
      $display("checks run %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
         mismatches++;
      end
   endtask : chk
   task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
      int k;
      k = 0;
      @(posedge clk_i);
      wb_cyc  <= 1'b1;
      wb_stb  <= 1'b1;
      wb_we   <= w;
      wb_adr  <= a;
      wb_sel  <= 4'h3;
      wb_wdat <= {16'h0, d};
      do begin
         @(posedge clk_i);
         k++;
      end while (ack !== 1'b1 && k < 50);
      q = rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we  <= 1'b0;
      if (k >= 50) begin
         chk("ack_wait", 32'h1, 32'h0);
         end_sim();
      end
   endtask : xfer
   task automatic per_of(input logic w);
      repeat (2) begin
         p = 0;
         do begin
            @(posedge clk_i);
            p++;
         end while ((w ? per_t : cpu_t) !== 1'b1 && p < 100);
      end
   endtask : per_of
   task automatic key;
      xfer(1'b1, ADR_WDKEY, 16'h00a5);
      xfer(1'b1, ADR_WDKEY, 16'h005a);
   endtask : key
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      por_i <= 1'b0;
      xfer(1'b0, ADR_GEAR, 16'h0);
      chk("gear_rst", 32'hcf00, q);
      xfer(1'b0, ADR_PLL, 16'h0);
      chk("pll_rst", 32'h0, q);
      xfer(1'b0, ADR_WDKEY, 16'h0);
      chk("key_rd", 32'h0, q);
      xfer(1'b0, ADR_WDCYC, 16'h0);
      chk("wdcyc_rst", 32'h0, q);
      xfer(1'b0, 8'h10, 16'h0);
      chk("unmapped", 32'h0, q);
      for (int g = 0; g < 4; g++) begin
         xfer(1'b1, ADR_GEAR, 16'((g << 14) | (g << 10) | 16'h0300));
         xfer(1'b1, ADR_GEAR, 16'((g << 14) | ((3 - g) << 10) | 16'h0300));
         xfer(1'b0, ADR_GEAR, 16'h0);
         chk("gear_rd", (g << 14) | ((3 - g) << 10) | 32'h300, q);
         per_of(1'b0);
         chk("cpu_period", 2 << g, p);
         per_of(1'b1);
         chk("per_period", 16 >> g, p);
      end
      xfer(1'b1, ADR_GEAR, 16'h0200);
      per_of(1'b1);
      chk("pll_period", 3, p);
      xfer(1'b1, ADR_PLL, 16'h4000);
      repeat (2) @(posedge clk_i);
      chk("mult_lock", 0, mult);
      xfer(1'b1, ADR_GEAR, 16'h0300);
      xfer(1'b1, ADR_PLL, 16'h4800);
      repeat (2) @(posedge clk_i);
      chk("mult_set", 1, mult);
      chk("run_off", 0, pll_run);
      xfer(1'b1, ADR_GEAR, 16'h0200);
      repeat (2) @(posedge clk_i);
      chk("ref_keep", 1, ref_src);
      xfer(1'b1, ADR_PLL, 16'h4000);
      repeat (2) @(posedge clk_i);
      chk("run_on", 1, pll_run);
      stby <= 3'h1;
      repeat (2) @(posedge clk_i);
      chk("run_stop", 0, pll_run);
      xfer(1'b0, ADR_PLL, 16'h0);
      chk("stop_bit", 32'h4000, q);
      stby <= 3'h0;
      xfer(1'b1, ADR_GEAR, 16'hd300);
      repeat (2) @(posedge clk_i);
      xfer(1'b0, ADR_GEAR, 16'h0);
      chk("dbl_ack", 32'hf300, q);
      chk("dbl_out", 1, dbl);
      per_of(1'b0);
      chk("dbl_cpu", 2, p);
      xfer(1'b1, ADR_GEAR, 16'h2300);
      repeat (2) @(posedge clk_i);
      xfer(1'b0, ADR_GEAR, 16'h0);
      chk("ack_ro", 32'h0300, q);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      xfer(1'b0, ADR_PLL, 16'h0);
      chk("pll_keep", 32'h4000, q);
      xfer(1'b0, ADR_GEAR, 16'h0);
      chk("gear_rst2", 32'hcf00, q);
      por_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      por_i <= 1'b0;
      xfer(1'b0, ADR_PLL, 16'h0);
      chk("pll_por", 32'h0, q);
      for (int c = 0; c < 4; c++) begin
         xfer(1'b1, ADR_WDCYC, 16'(c << 8));
         xfer(1'b0, ADR_WDCYC, 16'h0);
         chk("wdcyc_rd", c << 8, q);
         key();
         key();
         n = 0;
         while (wd_rst !== 1'b1 && n < 3000) begin
            @(posedge clk_i);
            n++;
         end
         chk("wd_early", 1, n >= (16 << (2 * c)));
         chk("wd_late", 1, n <= (32 << (2 * c)) + 8);
      end
      xfer(1'b1, ADR_WDCYC, 16'h0);
      key();
      n = hits;
      repeat (12) begin
         key();
         repeat (6) @(posedge clk_i);
      end
      chk("wd_served", 0, hits - n);
      xfer(1'b1, ADR_GEAR, 16'h0200);
      key();
      n = 0;
      while (wd_rst !== 1'b1 && n < 3000) begin
         @(posedge clk_i);
         n++;
      end
      chk("wd_pll_early", 1, n >= 24);
      chk("wd_pll_late", 1, n <= 56);
      xfer(1'b1, ADR_GEAR, 16'h0300);
      n = hits;
      repeat (12) begin
         xfer(1'b1, ADR_WDKEY, 16'h005a);
         repeat (6) @(posedge clk_i);
      end
      chk("wd_bad_key", 1, hits > n);
      for (int s = 0; s < 3; s++) begin
         stby <= 3'(1 << s);
         repeat (4) @(posedge clk_i);
         n = hits;
         repeat (200) @(posedge clk_i);
         chk("wd_standby", 0, hits - n);
         stby <= 3'h0;
         key();
      end
      end_sim();
   end
endmodule : testbench
bind cgw_clock_ctrl cgw_chk #(.WD_EXP_BASE(WD_EXP_BASE)) cgw_chk_inst (
   .clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .stop_i(stop_i), .sleep_i(sleep_i), .bus_hold_i(bus_hold_i), .ref_src_o(ref_src_o),
   .pll_run_o(pll_run_o), .pll_mult_o(pll_mult_o), .wd_reset_o(wd_reset_o));
